// *** hw/cci2c_regs.vh ***
// Purpose: Register map, field positions, reset values and timing counts
// Assumes: 8-bit serial control bus register space, 125 MHz system clock
// Notes: Definitions only
`ifndef CCI2C_REGS_VH
`define CCI2C_REGS_VH

`define CCI2C_ADDR_OSC 8'h14
`define CCI2C_ADDR_WDOG 8'h16
`define CCI2C_ADDR_I2CCTL 8'h17
`define CCI2C_ADDR_SCLHI 8'h18
`define CCI2C_ADDR_SCLLO 8'h19

`define CCI2C_RST_OSC_SRC 2'h0
`define CCI2C_RST_WDOG 8'hFE
`define CCI2C_RST_I2CCTL 8'h5E
`define CCI2C_RST_SCLHI 8'hA1
`define CCI2C_RST_SCLLO 8'hA5

`define CCI2C_OSC_SRC_MSB 2
`define CCI2C_OSC_SRC_LSB 1
`define CCI2C_OSC_BUILTIN_SELFTEST_BIT 0
`define CCI2C_WD_TMO_MSB 7
`define CCI2C_WD_TMO_LSB 1
`define CCI2C_WD_DIS_BIT 0
`define CCI2C_PASS_ALL_BIT 7
`define CCI2C_HOLD_MSB 5
`define CCI2C_HOLD_LSB 4
`define CCI2C_FILT_MSB 3
`define CCI2C_FILT_LSB 0

`define CCI2C_SRC_PCLK 2'h0
`define CCI2C_SRC_OSC33 2'h1
`define CCI2C_SRC_RSVD 2'h2
`define CCI2C_SRC_OSC25 2'h3

`define CCI2C_MODE_PCLK 2'h0
`define CCI2C_MODE_33M 2'h1
`define CCI2C_MODE_25M 2'h2
`define CCI2C_MODE_12M5 2'h3

`define CCI2C_CLK_KHZ 125000
`define CCI2C_WD_TICK_US 2000
`define CCI2C_WD_TICK_CYC (`CCI2C_WD_TICK_US * (`CCI2C_CLK_KHZ / 1000))
`define CCI2C_STEP40_NS 40
`define CCI2C_STEP40_CYC ((`CCI2C_STEP40_NS * `CCI2C_CLK_KHZ) / 1000000)
`define CCI2C_STEP5_NS 5

`endif

// *** hw/cci2c_glitch.v ***
// Purpose: Glitch filter for one synchronised I2C line
// Assumes: Input already passed a two-stage synchroniser
// Notes: Output follows input only after it differs for more than limit cycles
`timescale 1ns/100ps
`default_nettype none
module cci2c_glitch (
  input wire clk,
  input wire rst_n,
  input wire d,
  input wire [3:0] limit,
  output reg q
);
  reg [3:0] cnt_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b1;
      cnt_r <= 4'h0;
    end else if (d == q) begin
      cnt_r <= 4'h0;
    end else if (cnt_r >= limit) begin
      q <= d;
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule // cci2c_glitch
`default_nettype wire

// *** hw/cci2c_top.v ***
// Purpose: Control-channel I2C timing and configuration registers
// Assumes: Register port driven by serial control bus slave on SYS_CLK
// Notes: Timing steps use SYS_CLK, not the oscillator, as time base
`timescale 1ns/100ps
`default_nettype none
`include "cci2c_regs.vh"

// Behaviour
// - Source code 00 picks pixel clock, 11 picks 25 MHz oscillator.
// - Code 01 picks 33 MHz oscillator; reserved code 10 is never applied.
// - Low-frequency mode forces the oscillator to 12.5 MHz.
// - Watchdog aborts control-channel transactions that overrun the timeout.
// - Timeout field bits 7:1 counts in 2 ms steps.
// - Watchdog control bit one disables watchdog, zero enables it.
// - Forward-all set passes every access not addressed to own ID.
// - Forward-all clear passes only remote deserializer or remote target IDs.
// - Bits 5:4 set SDA input hold after SCL in 40 ns steps.
// - Bits 3:0 set widest rejected SCL/SDA glitch in 5 ns steps.
// - SCL high field sets master SCL high width in 40 ns steps.
// - SCL high field resets to 0xA1.
// - SCL low field, reset 0xA5, sets master low time and target setup.
module cci2c_top #(
  parameter WD_TICK_CYCLES = `CCI2C_WD_TICK_CYC
) (
  input wire SYS_CLK,
  input wire RESET_N,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [7:0] REG_RDATA,
  input wire LOW_FREQ_MODE,
  input wire BUILTIN_SELFTEST_ACTIVE,
  output reg [1:0] OSC_MODE,
  input wire XFER_START,
  input wire XFER_DONE,
  output reg XFER_ABORT,
  output reg XFER_ACTIVE,
  input wire ADDR_VALID,
  input wire [6:0] ADDR_ID,
  input wire [6:0] OWN_ID,
  input wire [6:0] REMOTE_DES_ID,
  input wire [6:0] REMOTE_TGT_ID,
  output reg FWD_VALID,
  output reg FWD_PASS,
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SCL_FILT,
  output reg SDA_HELD,
  input wire MST_EN,
  output wire SCL_OUT,
  output reg SCL_OE,
  input wire TGT_DATA_SET,
  output reg TGT_SCL_RELEASE
);
  localparam ST_IDLE = 2'h0;
  localparam ST_HIGH = 2'h1;
  localparam ST_LOW = 2'h2;
  localparam [31:0] STEP40_FULL = `CCI2C_STEP40_CYC;
  localparam [10:0] STEP40 = STEP40_FULL[10:0];
  localparam [31:0] TICK_FULL = WD_TICK_CYCLES - 1;
  localparam [17:0] TICK_LAST = TICK_FULL[17:0];

  reg [1:0] osc_src_r;
  reg [7:0] wdog_r;
  reg [7:0] i2cctl_r;
  reg [7:0] sclhi_r;
  reg [7:0] scllo_r;
  reg [1:0] scl_sync_r;
  reg [1:0] sda_sync_r;
  wire [1:0] filt_out;
  reg [3:0] filt_cyc;
  reg [6:0] filt_ns;
  reg [15:0] sda_dly_r;
  wire [16:0] sda_taps;
  reg [4:0] hold_idx;
  reg [17:0] tick_cnt_r;
  reg [6:0] ticks_r;
  reg [1:0] st_r;
  reg [1:0] st_nxt;
  reg [10:0] ph_cnt_r;
  reg [10:0] ph_cnt_nxt;
  reg [10:0] hi_cyc;
  reg [10:0] lo_cyc;
  reg [10:0] setup_cnt_r;
  reg setup_busy_r;
  wire wd_dis;
  wire [6:0] wd_tmo;
  wire tick;
  wire pass_calc;

  assign wd_dis = wdog_r[`CCI2C_WD_DIS_BIT];
  assign wd_tmo = wdog_r[`CCI2C_WD_TMO_MSB:`CCI2C_WD_TMO_LSB];
  assign SCL_OUT = 1'b0;

  // Register writes
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      osc_src_r <= `CCI2C_RST_OSC_SRC;
      wdog_r <= `CCI2C_RST_WDOG;
      i2cctl_r <= `CCI2C_RST_I2CCTL;
      sclhi_r <= `CCI2C_RST_SCLHI;
      scllo_r <= `CCI2C_RST_SCLLO;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `CCI2C_ADDR_OSC: begin
          // Reserved source code would leave the clock undefined, so it is dropped
          if (REG_WDATA[`CCI2C_OSC_SRC_MSB:`CCI2C_OSC_SRC_LSB] != `CCI2C_SRC_RSVD) begin
            osc_src_r <= REG_WDATA[`CCI2C_OSC_SRC_MSB:`CCI2C_OSC_SRC_LSB];
          end
        end
        `CCI2C_ADDR_WDOG: wdog_r <= REG_WDATA;
        `CCI2C_ADDR_I2CCTL: i2cctl_r <= {REG_WDATA[7], i2cctl_r[6], REG_WDATA[5:0]};
        `CCI2C_ADDR_SCLHI: sclhi_r <= REG_WDATA;
        `CCI2C_ADDR_SCLLO: scllo_r <= REG_WDATA;
        default: begin
        end
      endcase
    end
  end

  // Register reads, registered; unmapped addresses read zero
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `CCI2C_ADDR_OSC: REG_RDATA <= {5'h00, osc_src_r, BUILTIN_SELFTEST_ACTIVE};
        `CCI2C_ADDR_WDOG: REG_RDATA <= wdog_r;
        `CCI2C_ADDR_I2CCTL: REG_RDATA <= i2cctl_r;
        `CCI2C_ADDR_SCLHI: REG_RDATA <= sclhi_r;
        `CCI2C_ADDR_SCLLO: REG_RDATA <= scllo_r;
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end

  // Oscillator selection
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      OSC_MODE <= `CCI2C_MODE_PCLK;
    end else if (LOW_FREQ_MODE) begin
      OSC_MODE <= `CCI2C_MODE_12M5;
    end else begin
      case (osc_src_r)
        `CCI2C_SRC_PCLK: OSC_MODE <= `CCI2C_MODE_PCLK;
        `CCI2C_SRC_OSC33: OSC_MODE <= `CCI2C_MODE_33M;
        `CCI2C_SRC_OSC25: OSC_MODE <= `CCI2C_MODE_25M;
        default: OSC_MODE <= `CCI2C_MODE_PCLK;
      endcase
    end
  end

  // Watchdog: a zero timeout aborts on the first tick, hence software keeps it nonzero
  assign tick = XFER_ACTIVE && (tick_cnt_r == TICK_LAST);
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      XFER_ACTIVE <= 1'b0;
      XFER_ABORT <= 1'b0;
      tick_cnt_r <= 18'h00000;
      ticks_r <= 7'h00;
    end else begin
      XFER_ABORT <= 1'b0;
      if (XFER_START) begin
        XFER_ACTIVE <= 1'b1;
        tick_cnt_r <= 18'h00000;
        ticks_r <= 7'h00;
      end else if (XFER_DONE || !XFER_ACTIVE) begin
        XFER_ACTIVE <= 1'b0;
        tick_cnt_r <= 18'h00000;
        ticks_r <= 7'h00;
      end else if (wd_dis) begin
        tick_cnt_r <= 18'h00000;
        ticks_r <= 7'h00;
      end else if (tick) begin
        tick_cnt_r <= 18'h00000;
        if ((ticks_r + 7'h01) >= wd_tmo) begin
          XFER_ABORT <= 1'b1;
          XFER_ACTIVE <= 1'b0;
          ticks_r <= 7'h00;
        end else begin
          ticks_r <= ticks_r + 7'h01;
        end
      end else begin
        tick_cnt_r <= tick_cnt_r + 18'h00001;
      end
    end
  end

  // Forwarding decision; own ID is never passed to the link
  assign pass_calc = (ADDR_ID != OWN_ID) &&
                     (i2cctl_r[`CCI2C_PASS_ALL_BIT] ||
                      (ADDR_ID == REMOTE_DES_ID) || (ADDR_ID == REMOTE_TGT_ID));
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FWD_VALID <= 1'b0;
      FWD_PASS <= 1'b0;
    end else begin
      FWD_VALID <= ADDR_VALID;
      if (ADDR_VALID) begin
        FWD_PASS <= pass_calc;
      end
    end
  end

  // Pin synchronisers
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
    end else begin
      scl_sync_r <= {scl_sync_r[0], SCL_IN};
      sda_sync_r <= {sda_sync_r[0], SDA_IN};
    end
  end

  // Filter depth in 5 ns units rounded up to whole 8 ns clock cycles
  always @* begin
    filt_ns = {3'h0, i2cctl_r[`CCI2C_FILT_MSB:`CCI2C_FILT_LSB]} * 7'h05 + 7'h07;
    filt_cyc = filt_ns[6:3];
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
      cci2c_glitch u_filt (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .d(gi == 0 ? scl_sync_r[1] : sda_sync_r[1]),
        .limit(filt_cyc),
        .q(filt_out[gi])
      );
    end
  endgenerate

  // SDA hold: delayed SDA tap, up to three 40 ns steps
  assign sda_taps = {sda_dly_r, filt_out[1]};
  always @* begin
    hold_idx = 5'h00;
    case (i2cctl_r[`CCI2C_HOLD_MSB:`CCI2C_HOLD_LSB])
      2'h0: hold_idx = 5'h00;
      2'h1: hold_idx = STEP40[4:0];
      2'h2: hold_idx = STEP40[3:0] * 5'h02;
      default: hold_idx = STEP40[3:0] * 5'h03;
    endcase
  end
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sda_dly_r <= 16'hFFFF;
      SDA_HELD <= 1'b1;
      SCL_FILT <= 1'b1;
    end else begin
      sda_dly_r <= {sda_dly_r[14:0], filt_out[1]};
      SDA_HELD <= sda_taps[hold_idx];
      SCL_FILT <= filt_out[0];
    end
  end

  // Master SCL generator; high phase waits while a target stretches SCL
  always @* begin
    hi_cyc = (sclhi_r == 8'h00) ? 11'h001 : sclhi_r * STEP40;
    lo_cyc = (scllo_r == 8'h00) ? 11'h001 : scllo_r * STEP40;
  end
  always @* begin
    st_nxt = st_r;
    ph_cnt_nxt = ph_cnt_r;
    case (st_r)
      ST_IDLE: begin
        if (MST_EN) begin
          st_nxt = ST_HIGH;
          ph_cnt_nxt = 11'h000;
        end
      end
      ST_HIGH: begin
        if (!MST_EN) begin
          st_nxt = ST_IDLE;
        end else if (filt_out[0]) begin
          if (ph_cnt_r + 11'h001 >= hi_cyc) begin
            st_nxt = ST_LOW;
            ph_cnt_nxt = 11'h000;
          end else begin
            ph_cnt_nxt = ph_cnt_r + 11'h001;
          end
        end
      end
      ST_LOW: begin
        if (ph_cnt_r + 11'h001 >= lo_cyc) begin
          st_nxt = MST_EN ? ST_HIGH : ST_IDLE;
          ph_cnt_nxt = 11'h000;
        end else begin
          ph_cnt_nxt = ph_cnt_r + 11'h001;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
        ph_cnt_nxt = 11'h000;
      end
    endcase
  end
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r <= ST_IDLE;
      ph_cnt_r <= 11'h000;
      SCL_OE <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ph_cnt_r <= ph_cnt_nxt;
      SCL_OE <= (st_nxt == ST_LOW);
    end
  end

  // Target setup: SCL held low until data has stood for the low-time count
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      setup_busy_r <= 1'b0;
      setup_cnt_r <= 11'h000;
      TGT_SCL_RELEASE <= 1'b0;
    end else begin
      TGT_SCL_RELEASE <= 1'b0;
      if (TGT_DATA_SET) begin
        setup_busy_r <= 1'b1;
        setup_cnt_r <= 11'h000;
      end else if (setup_busy_r) begin
        if (setup_cnt_r + 11'h001 >= lo_cyc) begin
          setup_busy_r <= 1'b0;
          TGT_SCL_RELEASE <= 1'b1;
        end else begin
          setup_cnt_r <= setup_cnt_r + 11'h001;
        end
      end
    end
  end
endmodule // cci2c_top
`default_nettype wire

// *** test/cci2c_far.sv ***
// Purpose: Local I2C bus and remote end of the control channel
// Assumes: Pull-ups on SCL and SDA
// Notes: lat 0 is a remote end that never answers
`timescale 1ns/100ps
`default_nettype none
module cci2c_far (
  input wire clk,
  input wire scl_oe,
  input wire sda_lo,
  input wire start,
  input wire [3:0] lat,
  output wire scl,
  output wire sda,
  output reg done
);
  reg [3:0] n_r = 4'h0;
  // Open drain: a released line floats up to the pull-up
  assign scl = !scl_oe;
  assign sda = !sda_lo;
  initial done = 1'b0;
  always @(posedge clk) begin
    done <= (n_r == 4'h1);
    if (start) n_r <= lat;
    else if (n_r != 4'h0) n_r <= n_r - 4'h1;
  end
endmodule // cci2c_far
`default_nettype wire

// *** test/cci2c_props.sv ***
// Purpose: Port checks for cci2c_top
// Assumes: Timing fields are rewritten only while idle
// Notes: Timing fields are shadowed from register writes
`timescale 1ns/100ps
`default_nettype none
module cci2c_props #(
  parameter WD_TICK_CYCLES = 250000
) (
  input wire SYS_CLK,
  input wire RESET_N,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire LOW_FREQ_MODE,
  input wire [1:0] OSC_MODE,
  input wire XFER_START,
  input wire XFER_DONE,
  input wire XFER_ABORT,
  input wire XFER_ACTIVE,
  input wire ADDR_VALID,
  input wire [6:0] ADDR_ID,
  input wire [6:0] OWN_ID,
  input wire [6:0] REMOTE_DES_ID,
  input wire FWD_VALID,
  input wire FWD_PASS,
  input wire MST_EN,
  input wire SCL_OE,
  input wire TGT_DATA_SET,
  input wire TGT_SCL_RELEASE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  reg [7:0] wd_r, hi_r, lo_r;
  reg [31:0] wc_r, oe_r, lw_r, tc_r;
  // Zero timeout behaves as one tick
  wire [31:0] lim = (wd_r[7:1] == 7'h00 ? 1 : wd_r[7:1]) * WD_TICK_CYCLES + 1;
  function automatic [31:0] cyc(input [7:0] f);
    cyc = (f == 8'h00) ? 1 : f * 5;
  endfunction
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wd_r <= 8'hFE;
      hi_r <= 8'hA1;
      lo_r <= 8'hA5;
      wc_r <= 0;
      oe_r <= 0;
      lw_r <= 0;
      tc_r <= 0;
    end else begin
      if (REG_WR && REG_ADDR == 8'h16) wd_r <= REG_WDATA;
      if (REG_WR && REG_ADDR == 8'h18) hi_r <= REG_WDATA;
      if (REG_WR && REG_ADDR == 8'h19) lo_r <= REG_WDATA;
      wc_r <= XFER_START ? 1 : (XFER_DONE || wc_r == 0) ? 0 : wc_r + 1;
      oe_r <= SCL_OE ? oe_r + 1 : 0;
      lw_r <= (SCL_OE || !MST_EN) ? 0 : lw_r + 1;
      tc_r <= TGT_DATA_SET ? 1 : (tc_r == 0) ? 0 : tc_r + 1;
    end
  end
  property p_own; ADDR_VALID && ADDR_ID == OWN_ID |=> FWD_VALID && !FWD_PASS; endproperty
  a_own: assert property (p_own) else $error("own id forwarded");
  property p_des; ADDR_VALID && ADDR_ID != OWN_ID && ADDR_ID == REMOTE_DES_ID |=> FWD_PASS;
  endproperty
  a_des: assert property (p_des) else $error("remote id not forwarded");
  property p_lf; LOW_FREQ_MODE [*2] |-> OSC_MODE == 2'h3; endproperty
  a_lf: assert property (p_lf) else $error("low freq mode ignored");
  property p_abort; XFER_ABORT |-> !XFER_ACTIVE ##1 !XFER_ABORT; endproperty
  a_abort: assert property (p_abort) else $error("abort shape wrong");
  property p_when; XFER_ABORT |-> wc_r == lim && !wd_r[0]; endproperty
  a_when: assert property (p_when) else $error("abort at wrong time");
  property p_due; wc_r == lim && !wd_r[0] && !XFER_DONE |-> XFER_ABORT; endproperty
  a_due: assert property (p_due) else $error("abort missing");
  property p_act; XFER_START |=> XFER_ACTIVE; endproperty
  a_act: assert property (p_act) else $error("transfer not watched");
  property p_lo; $fell(SCL_OE) |-> oe_r == cyc(lo_r); endproperty
  a_lo: assert property (p_lo) else $error("scl low width wrong");
  property p_hi; $rose(SCL_OE) && MST_EN |-> lw_r >= cyc(hi_r) && lw_r < cyc(hi_r) + 20;
  endproperty
  a_hi: assert property (p_hi) else $error("scl high width wrong");
  property p_tgt; TGT_SCL_RELEASE |-> tc_r == cyc(lo_r) + 1; endproperty
  a_tgt: assert property (p_tgt) else $error("target setup wrong");
  c_abort: cover property (XFER_ABORT);
  c_pass: cover property (FWD_VALID && FWD_PASS);
  c_low: cover property ($fell(SCL_OE));
endmodule // cci2c_props
`default_nettype wire

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for cci2c_top
// Assumes: Watchdog tick shortened to W cycles
// Notes: Small timing fields keep every phase short
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam W = 20;
  reg SYS_CLK = 0, RESET_N = 0, REG_WR = 0, REG_RD = 0, LOW_FREQ_MODE = 0, BUILTIN_SELFTEST_ACTIVE = 0;
  reg ADDR_VALID = 0, MST_EN = 0, TGT_DATA_SET = 0, XFER_START = 0, sda_lo = 0;
  reg [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00;
  reg [6:0] ADDR_ID = 7'h00, OWN_ID = 7'h10, REMOTE_DES_ID = 7'h20, REMOTE_TGT_ID = 7'h30;
  reg [3:0] lat = 4'h0;
  wire [7:0] REG_RDATA;
  wire [1:0] OSC_MODE;
  wire XFER_DONE, XFER_ABORT, XFER_ACTIVE, FWD_VALID, FWD_PASS, SCL_IN, SDA_IN, SCL_FILT;
  wire SDA_HELD, SCL_OUT, SCL_OE, TGT_SCL_RELEASE;
  integer error_cnt = 0, n_tests = 0, i, k, c, h;
  cci2c_top #(.WD_TICK_CYCLES(W)) cci2c_top_inst (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .LOW_FREQ_MODE(LOW_FREQ_MODE), .BUILTIN_SELFTEST_ACTIVE(BUILTIN_SELFTEST_ACTIVE),
    .OSC_MODE(OSC_MODE), .XFER_START(XFER_START), .XFER_DONE(XFER_DONE),
    .XFER_ABORT(XFER_ABORT), .XFER_ACTIVE(XFER_ACTIVE), .ADDR_VALID(ADDR_VALID),
    .ADDR_ID(ADDR_ID), .OWN_ID(OWN_ID), .REMOTE_DES_ID(REMOTE_DES_ID),
    .REMOTE_TGT_ID(REMOTE_TGT_ID), .FWD_VALID(FWD_VALID), .FWD_PASS(FWD_PASS),
    .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SCL_FILT(SCL_FILT), .SDA_HELD(SDA_HELD),
    .MST_EN(MST_EN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .TGT_DATA_SET(TGT_DATA_SET),
    .TGT_SCL_RELEASE(TGT_SCL_RELEASE));
  cci2c_far cci2c_far_inst (.clk(SYS_CLK), .scl_oe(SCL_OE), .sda_lo(sda_lo), .start(XFER_START),
    .lat(lat), .scl(SCL_IN), .sda(SDA_IN), .done(XFER_DONE));
  task chk(input string nm, input [31:0] ex, got);
    begin
      n_tests = n_tests + 1;
      if (got !== ex) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %s expected %0h seen %0h", nm, ex, got);
      end
    end
  endtask
  task tk(input integer n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  task wr(input [7:0] a, d);
    begin
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, ex);
    begin
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      tk(1);
      chk("rdata", ex, REG_RDATA);
    end
  endtask
  task osc(input [7:0] d, input [1:0] ex);
    begin
      wr(8'h14, d);
      tk(2);
      chk("osc", ex, OSC_MODE);
    end
  endtask
  // h gets the cycle of the first abort, 0 if none
  task wd(input [3:0] l);
    begin
      @(posedge SYS_CLK);
      lat <= l;
      XFER_START <= 1'b1;
      @(posedge SYS_CLK);
      XFER_START <= 1'b0;
      h = 0;
      for (k = 1; k <= 100; k = k + 1) begin
        @(posedge SYS_CLK);
        if (XFER_ABORT === 1'b1 && h == 0) h = k;
      end
    end
  endtask
  // SDA pulled low for len cycles; c gets the filtered response delay
  task sd(input integer len);
    begin
      @(posedge SYS_CLK);
      sda_lo <= 1'b1;
      c = 0;
      for (k = 1; k < 40; k = k + 1) begin
        @(posedge SYS_CLK);
        if (k == len) sda_lo <= 1'b0;
        if (SDA_HELD === 1'b0 && c == 0) c = k;
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial forever #4 SYS_CLK = ~SYS_CLK;
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    $display("ERROR watchdog expected done seen timeout");
    conclude;
  end
  initial begin
    tk(20);
    RESET_N <= 1'b1;
    rd(8'h14, 8'h00);
    rd(8'h16, 8'hFE);
    rd(8'h17, 8'h5E);
    rd(8'h18, 8'hA1);
    rd(8'h19, 8'hA5);
    rd(8'h15, 8'h00);
    BUILTIN_SELFTEST_ACTIVE <= 1'b1;
    osc(8'hFF, 2'h2);
    rd(8'h14, 8'h07);
    osc(8'h00, 2'h0);
    osc(8'h02, 2'h1);
    osc(8'h04, 2'h1);
    LOW_FREQ_MODE <= 1'b1;
    osc(8'h06, 2'h3);
    wr(8'h17, 8'hFF);
    rd(8'h17, 8'hFF);
    for (i = 0; i < 10; i = i + 1) begin
      if (i == 5) wr(8'h17, 8'h02);
      @(posedge SYS_CLK);
      ADDR_ID <= 7'h10 * (i % 5 + 1);
      ADDR_VALID <= 1'b1;
      @(posedge SYS_CLK);
      ADDR_VALID <= 1'b0;
      tk(1);
      h = (ADDR_ID != OWN_ID) && (i < 5 || ADDR_ID == REMOTE_DES_ID || ADDR_ID == REMOTE_TGT_ID);
      chk("fwd", h, FWD_PASS);
    end
    sd(2);
    chk("glitch", 0, c);
    sd(3);
    h = c;
    chk("pass", 1, c > 0);
    wr(8'h17, 8'h12);
    sd(3);
    chk("hold", h + 5, c);
    wr(8'h16, 8'h04);
    wd(4'h0);
    chk("abort", 2 * W + 1, h);
    wd(4'h5);
    chk("noabort", 0, h);
    wr(8'h16, 8'h05);
    wd(4'h0);
    chk("dis", 0, h);
    chk("act", 1, XFER_ACTIVE);
    wd(4'h3);
    chk("act", 0, XFER_ACTIVE);
    wr(8'h17, 8'h00);
    wr(8'h18, 8'h02);
    wr(8'h19, 8'h03);
    MST_EN <= 1'b1;
    for (h = 0; SCL_OE !== 1'b1 && h < 99; h = h + 1) @(posedge SYS_CLK);
    chk("sclhi", 1, h >= 10 && h < 30);
    for (c = 0; SCL_OE === 1'b1 && c < 99; c = c + 1) @(posedge SYS_CLK);
    chk("scllo", 15, c);
    chk("sclfilt", 0, SCL_FILT);
    chk("sclout", 0, SCL_OUT);
    MST_EN <= 1'b0;
    tk(40);
    TGT_DATA_SET <= 1'b1;
    tk(1);
    TGT_DATA_SET <= 1'b0;
    for (c = 0; TGT_SCL_RELEASE !== 1'b1 && c < 99; c = c + 1) @(posedge SYS_CLK);
    chk("tgt", 16, c);
    conclude;
  end
endmodule // tb_top
bind cci2c_top cci2c_props #(.WD_TICK_CYCLES(WD_TICK_CYCLES)) cci2c_props_inst (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .LOW_FREQ_MODE(LOW_FREQ_MODE), .OSC_MODE(OSC_MODE),
  .XFER_START(XFER_START), .XFER_DONE(XFER_DONE), .XFER_ABORT(XFER_ABORT),
  .XFER_ACTIVE(XFER_ACTIVE), .ADDR_VALID(ADDR_VALID), .ADDR_ID(ADDR_ID), .OWN_ID(OWN_ID),
  .REMOTE_DES_ID(REMOTE_DES_ID), .FWD_VALID(FWD_VALID), .FWD_PASS(FWD_PASS),
  .MST_EN(MST_EN), .SCL_OE(SCL_OE), .TGT_DATA_SET(TGT_DATA_SET),
  .TGT_SCL_RELEASE(TGT_SCL_RELEASE));
`default_nettype wire
